// *** design/oct_trip_logic.sv ***
// Overcurrent trip logic: filtered fault inputs, gate high-Z disable, AXI4-Lite registers.
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: The inverter board holds its correction-stage fault line low during overcurrent.
// RULE2: Interrupt channel two catches the fault line's falling edge and flags an error.
// RULE3: That line is noise-filtered, sampled at the bus clock divided by sixty-four.
// RULE4: A trip puts the PWM gate outputs into high impedance without software.
// RULE5: The trip comes from the inverter error on the external trip input.
// RULE6: Gates stay high impedance and the event stands until software clears it.
module oct_trip_logic
  import oct_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        pfcFaultN,
  input  wire logic        externalTripInputN,
  input  wire logic [2:0]  pwmGateIn,
  output logic      [2:0]  pwmGateOut,
  output logic      [2:0]  pwmGateOe,
  output logic             irq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------------------
  // Input synchronisers and sample-rate dividers
  // ----------------------------------------------------------------------------
  logic [1:0] pfcSync_r;
  logic [1:0] tripSync_r;
  logic [5:0] pfcDiv_r;
  logic [4:0] tripDiv_r;
  logic       pfcSampleEn;
  logic       tripSampleEn;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pfcSync_r  <= 2'h3;
      tripSync_r <= 2'h3;
    end
    else
    begin
      pfcSync_r  <= {pfcSync_r[0], pfcFaultN};
      tripSync_r <= {tripSync_r[0], externalTripInputN};
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pfcDiv_r  <= 6'h00;
      tripDiv_r <= 5'h00;
    end
    else
    begin
      pfcDiv_r  <= pfcDiv_r + 6'h01;
      tripDiv_r <= tripDiv_r + 5'h01;
    end
  end

  assign pfcSampleEn  = (pfcDiv_r == 6'(OCT_PFC_DIV - 1)); // RULE3
  assign tripSampleEn = (tripDiv_r == 5'(OCT_TRIP_DIV - 1));

  // ----------------------------------------------------------------------------
  // Noise filters and edge detection
  // ----------------------------------------------------------------------------
  logic pfcFilt;
  logic tripFilt;
  logic pfcFiltPrev_r;
  logic pfcFall;

  oct_filter #(.SAMPLES(OCT_FILT_SAMPLES), .INIT(1'b1)) uPfcFilter ( // RULE3
    .mclk     (mclk),
    .reset    (reset),
    .sampleEn (pfcSampleEn),
    .din      (pfcSync_r[1]),
    .dout     (pfcFilt)
  );

  oct_filter #(.SAMPLES(OCT_FILT_SAMPLES), .INIT(1'b1)) uTripFilter (
    .mclk     (mclk),
    .reset    (reset),
    .sampleEn (tripSampleEn),
    .din      (tripSync_r[1]),
    .dout     (tripFilt)
  );

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pfcFiltPrev_r <= 1'b1;
    else
      pfcFiltPrev_r <= pfcFilt;
  end

  assign pfcFall = pfcFiltPrev_r & ~pfcFilt; // RULE2

  // ----------------------------------------------------------------------------
  // Control, trip latch and status
  // ----------------------------------------------------------------------------
  logic [2:0]          ctrl_r;
  logic                tripped_r;
  oct_ev_t             status_r;
  oct_ev_t             mask_r;
  oct_ev_t             events;
  logic                clearTrip;
  logic                statusRead;
  logic                tripEvent;

  // The trip is level-qualified and wins over a clear, so a fault held low across a clear keeps the latch set.
  assign tripEvent = ctrl_r[OCT_CTRL_TRIP_EN_BIT] & ~tripFilt; // RULE5

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      tripped_r <= 1'b0;
    else if (tripEvent)
      tripped_r <= 1'b1; // RULE6
    else if (clearTrip)
      tripped_r <= 1'b0;
  end

  // High impedance is forced straight from the latch and the live trip event, with no software in the path.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      pwmGateOut <= 3'h0;
      pwmGateOe  <= 3'h0;
    end
    else
    begin
      pwmGateOut <= pwmGateIn;
      pwmGateOe  <= (tripped_r || tripEvent) ? 3'h0 : 3'h7; // RULE4
    end
  end

  assign events.pfc  = pfcFall & ctrl_r[OCT_CTRL_IRQ_EN_BIT]; // RULE2
  assign events.trip = tripEvent & ~tripped_r;

  // A set in the same cycle as the read-clear wins, so no event is lost.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      status_r <= '0;
    else
      status_r <= (statusRead ? oct_ev_t'('0) : status_r) | events; // RULE6
  end

  assign irq = |(status_r & mask_r);

  // ----------------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------------
  logic       awHeld_r;
  logic       wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic       doWrite;

  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld_r & ~s_axi_bvalid;
  assign doWrite       = awHeld_r & wHeld_r;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r  <= 32'h0000_0000;
      wStrb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      else if (doWrite)
        awHeld_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      else if (doWrite)
        wHeld_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= OCT_RESP_OKAY;
    end
    else if (doWrite)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awAddr_r == OCT_CTRL_ADDR || awAddr_r == OCT_MASK_ADDR)
                      ? OCT_RESP_OKAY : OCT_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  assign clearTrip = doWrite && awAddr_r == OCT_CTRL_ADDR && wStrb_r[0]
                     && wData_r[OCT_CTRL_CLEAR_BIT]; // RULE6

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= OCT_CTRL_RST;
      mask_r <= OCT_MASK_RST;
    end
    else if (doWrite && wStrb_r[0])
    begin
      if (awAddr_r == OCT_CTRL_ADDR)
        ctrl_r <= {1'b0, wData_r[1:0]};
      if (awAddr_r == OCT_MASK_ADDR)
        mask_r <= wData_r[OCT_EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign statusRead    = s_axi_arvalid && s_axi_arready && s_axi_araddr == OCT_STATUS_ADDR;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= OCT_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= OCT_RESP_OKAY;
      unique case (s_axi_araddr)
        OCT_CTRL_ADDR:   s_axi_rdata <= {29'h0, ctrl_r};
        OCT_STATUS_ADDR: s_axi_rdata <= {30'h0, status_r};
        OCT_MASK_ADDR:   s_axi_rdata <= {30'h0, mask_r};
        OCT_STATE_ADDR:  s_axi_rdata <= {29'h0, tripped_r, tripFilt, pfcFilt};
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= OCT_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  a_pfc_edge_event: assert property (@(posedge mclk) disable iff (reset) // RULE2
    $fell(pfcFilt) && ctrl_r[OCT_CTRL_IRQ_EN_BIT] && !statusRead |=> status_r.pfc)
    else $error("pfc falling edge did not set status");
  a_pfc_sample_rate: assert property (@(posedge mclk) disable iff (reset) // RULE3
    $changed(pfcFilt) |-> $past(pfcSampleEn, 2))
    else $error("pfc filter changed off its sample tick");
  a_gate_hiz_trip: assert property (@(posedge mclk) disable iff (reset) // RULE4
    tripEvent |=> pwmGateOe == 3'h0)
    else $error("gates not high impedance after trip");
  a_trip_source: assert property (@(posedge mclk) disable iff (reset) // RULE5
    $rose(tripped_r) |-> $past(!tripFilt && ctrl_r[OCT_CTRL_TRIP_EN_BIT]))
    else $error("trip latched without external trip input");
  a_trip_holds: assert property (@(posedge mclk) disable iff (reset) // RULE6
    tripped_r && !clearTrip |=> tripped_r && pwmGateOe == 3'h0)
    else $error("trip released without software clear");
  a_irq_level: assert property (@(posedge mclk) disable iff (reset) // RULE2
    !doWrite && |(events & mask_r) |=> irq)
    else $error("unmasked event did not raise irq");

endmodule : oct_trip_logic

// *** design/oct_pkg.sv ***
// Package holding constants, register map and carrier types of the overcurrent trip logic.
package oct_pkg;

  // ----------------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] OCT_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] OCT_STATUS_ADDR = 8'h04;
  localparam logic [7:0] OCT_MASK_ADDR   = 8'h08;
  localparam logic [7:0] OCT_STATE_ADDR  = 8'h0c;

  // ----------------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------------
  localparam int OCT_CTRL_IRQ_EN_BIT  = 0;
  localparam int OCT_CTRL_TRIP_EN_BIT = 1;
  localparam int OCT_CTRL_CLEAR_BIT   = 2;
  localparam int OCT_EV_PFC_BIT       = 0;
  localparam int OCT_EV_TRIP_BIT      = 1;
  localparam int OCT_EV_W             = 2;

  // ----------------------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------------------
  localparam logic [2:0]        OCT_CTRL_RST     = 3'h3;
  localparam logic [OCT_EV_W-1:0] OCT_MASK_RST   = 2'h0;
  localparam int                OCT_PFC_DIV      = 64;
  localparam int                OCT_TRIP_DIV     = 32;
  localparam int                OCT_FILT_SAMPLES = 3;
  localparam logic [1:0]        OCT_RESP_OKAY    = 2'h0;
  localparam logic [1:0]        OCT_RESP_SLVERR  = 2'h2;

  typedef struct packed {
    logic       trip;
    logic       pfc;
  } oct_ev_t;

endpackage : oct_pkg

// *** design/oct_filter.sv ***
// Sampled majority-free noise filter: output follows input after N equal samples.
`timescale 1ns/1ps
module oct_filter
  import oct_pkg::*;
#(
  parameter int SAMPLES = OCT_FILT_SAMPLES,
  parameter logic INIT  = 1'b1
)(
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic sampleEn,
  input  wire logic din,
  output logic      dout
);
  // The shift register needs at least two stages to compare samples.
  if (SAMPLES < 2 || SAMPLES > 8)
  begin : gBadSamples
    $error("oct_filter: SAMPLES out of range");
  end

  logic [SAMPLES-1:0] shift_r;

  // A level is accepted only once every stored sample agrees, so short spikes vanish.
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      shift_r <= {SAMPLES{INIT}};
    else if (sampleEn)
      shift_r <= {shift_r[SAMPLES-2:0], din};
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      dout <= INIT;
    else if (&shift_r)
      dout <= 1'b1;
    else if (~|shift_r)
      dout <= 1'b0;
  end
endmodule : oct_filter

// *** testbench/oct_board_model.sv ***
// Behavioural model of the inverter board's two active-low fault lines.
`timescale 1ns/1ps
module oct_board_model
(
  input  wire logic pfcOver,
  input  wire logic invErr,
  output logic      pfcFaultN,
  output logic      externalTripInputN
);
  // Both lines carry pull-ups on the board, so they rest high outside a fault.
  assign pfcFaultN          = !pfcOver;
  assign externalTripInputN = !invErr;
endmodule : oct_board_model

// *** testbench/oct_trip_logic_test.sv ***
// Self-checking bench for the overcurrent trip logic.
`timescale 1ns/1ps
module oct_trip_logic_test;
  import oct_pkg::*;
  localparam logic [33:0] FULL = 34'h3_ffff_ffff;
  logic        mclk, reset, pfcOver, invErr, irq, pfcFaultN, tripN;
  logic [2:0]  gate, gOut, gOe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [33:0] expQ[$];
  logic [33:0] mskQ[$];
  int          nFail, testsRun, n;

  oct_board_model oct_board_model_i (.pfcOver(pfcOver), .invErr(invErr),
    .pfcFaultN(pfcFaultN), .externalTripInputN(tripN));
  oct_trip_logic oct_trip_logic_i (.mclk(mclk), .reset(reset), .pfcFaultN(pfcFaultN),
    .externalTripInputN(tripN), .pwmGateIn(gate), .pwmGateOut(gOut), .pwmGateOe(gOe),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // ------------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // A write stays offered until the slave has taken both halves and answered.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(negedge mclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid && bready;
      if (done)
        check("bresp", bresp, er);
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      if (done)
        bready <= 1'b0;
    end
    if (!done)
    begin
      check("write timeout", 1, 0);
      test_done();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    logic ta, done;
    done = 1'b0;
    expQ.push_back(e);
    mskQ.push_back(m);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(negedge mclk);
      ta = arvalid && arready;
      done = rvalid && rready;
      @(posedge mclk);
      if (ta)
        arvalid <= 1'b0;
      if (done)
        rready <= 1'b0;
    end
    if (!done)
    begin
      check("read timeout", 1, 0);
      test_done();
    end
  endtask : rd

  always @(negedge mclk)
    if (rvalid === 1'b1 && rready === 1'b1)
    begin
      if (expQ.size() == 0)
        check("unexpected read", 1, 0);
      else
        check("read", {rresp, rdata} & mskQ.pop_front(), expQ.pop_front());
    end

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ------------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------------
  initial
  begin
    {reset, pfcOver, invErr, gate, awaddr, araddr, wdata} = {1'b1, 53'h0};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    wstrb = 4'hf;
    nFail = 0;
    testsRun = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd(OCT_CTRL_ADDR, {2'h0, 32'h3}, FULL);
    rd(OCT_MASK_ADDR, 0, FULL);
    rd(OCT_STATUS_ADDR, 0, FULL);
    rd(OCT_STATE_ADDR, 3, FULL);
    rd(8'h10, {OCT_RESP_SLVERR, 32'h0}, {2'h3, 32'h0});
    wr(8'h10, 32'h3, OCT_RESP_SLVERR);
    wr(OCT_STATUS_ADDR, 32'h3, OCT_RESP_SLVERR);
    wr(OCT_MASK_ADDR, 32'h3, OCT_RESP_OKAY);
    rd(OCT_MASK_ADDR, 3, FULL);
    rnd = 32'h25cf;
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      @(posedge mclk);
      gate <= rnd[2:0];
      @(posedge mclk);
      @(negedge mclk);
      check("gate out", gOut, rnd[2:0]);
      check("gate oe", gOe, 3'h7);
    end
    // A low pulse shorter than one sample period must be filtered away.
    @(posedge mclk);
    pfcOver <= 1'b1;
    repeat (40) @(posedge mclk);
    pfcOver <= 1'b0;
    repeat (300) @(posedge mclk);
    rd(OCT_STATUS_ADDR, 0, FULL);
    wr(OCT_MASK_ADDR, 32'h0, OCT_RESP_OKAY);
    pfcOver <= 1'b1;
    repeat (300) @(posedge mclk);
    @(negedge mclk);
    check("masked irq", irq, 0);
    rd(OCT_STATUS_ADDR, 1, FULL);
    pfcOver <= 1'b0;
    repeat (300) @(posedge mclk);
    wr(OCT_MASK_ADDR, 32'h3, OCT_RESP_OKAY);
    pfcOver <= 1'b1;
    for (n = 0; n < 400 && irq !== 1'b1; n++) @(negedge mclk);
    check("irq", irq, 1);
    if (n == 400)
      test_done();
    rd(OCT_STATUS_ADDR, 1, FULL);
    @(negedge mclk);
    check("irq cleared", irq, 0);
    @(posedge mclk);
    pfcOver <= 1'b0;
    repeat (300) @(posedge mclk);
    rd(OCT_STATUS_ADDR, 0, FULL);
    invErr <= 1'b1;
    for (n = 0; n < 300 && gOe !== 3'h0; n++) @(negedge mclk);
    check("trip oe", gOe, 0);
    if (n == 300)
      test_done();
    @(posedge mclk);
    invErr <= 1'b0;
    repeat (200) @(posedge mclk);
    @(negedge mclk);
    check("held oe", gOe, 0);
    check("trip irq", irq, 1);
    rd(OCT_STATE_ADDR, 7, FULL);
    rd(OCT_STATUS_ADDR, 2, FULL);
    wr(OCT_CTRL_ADDR, 32'h7, OCT_RESP_OKAY);
    for (n = 0; n < 10 && gOe !== 3'h7; n++) @(negedge mclk);
    check("cleared oe", gOe, 7);
    wr(OCT_CTRL_ADDR, 32'h1, OCT_RESP_OKAY);
    invErr <= 1'b1;
    repeat (300) @(posedge mclk);
    @(negedge mclk);
    check("disabled trip oe", gOe, 7);
    rd(OCT_STATE_ADDR, 1, FULL);
    invErr <= 1'b0;
    repeat (200) @(posedge mclk);
    test_done();
  end
endmodule : oct_trip_logic_test
